// ### isc_master_model.sv
/*
  Behavioural two-wire bus master: start, stop and byte transfers on
  open-drain levels, eight pclk per clock half (160 ns bit).
  Assumes the bench resolves both wires with pull-ups.
*/
`default_nettype none
module isc_master_model (
  input wire logic pclk,
  input wire logic scl_line,
  input wire logic sda_line,
  output var logic scl_drv,
  output var logic sda_drv,
  output var logic hung
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Bus phases
  initial begin
    scl_drv = 1'h1;
    sda_drv = 1'h1;
    hung = 1'h0;
  end
  task automatic half();
    repeat (8) @(posedge pclk);
  endtask
  task automatic start_cond();
    sda_drv <= 1'h0;
    half();
    scl_drv <= 1'h0;
    half();
  endtask
  task automatic stop_cond();
    sda_drv <= 1'h0;
    half();
    scl_drv <= 1'h1;
    half();
    sda_drv <= 1'h1;
    half();
  endtask
  // Data moves two pclk after clock fall, never together with it
  task automatic one_bit(input logic b, output logic r);
    int n;
    repeat (2) @(posedge pclk);
    sda_drv <= b;
    repeat (6) @(posedge pclk);
    scl_drv <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (scl_line !== 1'h1 && n < 400);
    if (n >= 400) hung <= 1'h1;
    // First edge of the high half is spent in the wait above
    repeat (7) @(posedge pclk);
    r = sda_line;
    scl_drv <= 1'h0;
  endtask
  task automatic xfer(input logic [7:0] b, output logic [7:0] got, output logic ack);
    for (int i = 7; i >= 0; i--) one_bit(b[i], got[i]);
    one_bit(1'h1, ack);
  endtask
endmodule // isc_master_model
`default_nettype wire

// ### isc_pin_sync.sv
/*
  Three-stage synchroniser for the clock and data pins, with level
  agreement filter and edge, start and stop detection.
  Assumes both pins idle high and are asynchronous to pclk.
*/
`default_nettype none
module isc_pin_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  isc_pins_if.src p
);
  // ==========================================================
  // Synchroniser stages, index 0 clock, 1 data
  localparam logic [2:0] SYNC_RESET = isc_pkg::SYNC_RESET;
  logic [1:0] pin_in;
  logic [1:0] s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
  logic rise_reg, rise_next, fall_reg, fall_next;
  logic start_reg, start_next, stop_reg, stop_next;

  assign pin_in = {sda_in, scl_in};

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_pin
      // Level only moves once stages two and three agree
      always_comb begin
        lvl_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : lvl_reg[i];
      end
    end
  endgenerate

  always_comb begin
    rise_next = lvl_next[0] & ~lvl_reg[0];
    fall_next = ~lvl_next[0] & lvl_reg[0];
    start_next = lvl_reg[0] & lvl_next[0] & lvl_reg[1] & ~lvl_next[1];
    stop_next = lvl_reg[0] & lvl_next[0] & ~lvl_reg[1] & lvl_next[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= SYNC_RESET[1:0];
      s2_reg <= SYNC_RESET[1:0];
      s3_reg <= SYNC_RESET[1:0];
      lvl_reg <= SYNC_RESET[1:0];
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      start_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      start_reg <= start_next;
      stop_reg <= stop_next;
    end
  end

  assign p.scl = lvl_reg[0];
  assign p.sda = lvl_reg[1];
  assign p.scl_rise = rise_reg;
  assign p.scl_fall = fall_reg;
  assign p.start = start_reg;
  assign p.stop = stop_reg;
endmodule // isc_pin_sync
`default_nettype wire

// ### isc_pins_if.sv
/*
  Filtered bus levels and bus events passed from the pin synchroniser
  to the slave engine.
  Assumes all signals are registered on pclk by the source.
*/
`default_nettype none
interface isc_pins_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  modport src (output scl, output sda, output scl_rise, output scl_fall,
    output start, output stop);
  modport dst (input scl, input sda, input scl_rise, input scl_fall,
    input start, input stop);
endinterface
`default_nettype wire

// ### isc_pkg.sv
/*
  Shared constants of the two-wire slave control block: register map,
  field positions, reset values and engine states.
  Assumes nothing about its surroundings.
*/
`default_nettype none
package isc_pkg;
  // ==========================================================
  // Register byte addresses
  localparam logic [31:0] CTRL_ADDR = 32'hffff0928;
  localparam logic [31:0] ALT_ADDR = 32'hffff0930;
  localparam logic [31:0] OWN_ADDR = 32'hffff0934;
  localparam logic [31:0] TXD_ADDR = 32'hffff0938;
  localparam logic [31:0] RXD_ADDR = 32'hffff093c;
  localparam logic [31:0] IST_ADDR = 32'hffff0940;
  localparam logic [31:0] IMSK_ADDR = 32'hffff0944;
  localparam logic [31:0] GST_ADDR = 32'hffff0948;
  // ==========================================================
  // Reset values and write masks
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_WMASK = 16'h07ff;
  localparam logic [9:0] OWN_RESET = 10'h000;
  localparam logic [7:0] ALT_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [5:0] IRQ_RESET = 6'h00;
  // ==========================================================
  // Control register fields
  localparam int B_SEN = 0;
  localparam int B_WIDE = 1;
  localparam int B_GCEN = 2;
  localparam int B_HGC = 3;
  localparam int B_GCCLR = 4;
  localparam int B_EARLY = 5;
  localparam int B_HOLD = 6;
  localparam int B_NACK = 7;
  localparam int B_STOPI = 8;
  localparam int B_RXI = 9;
  localparam int B_TXI = 10;
  // ==========================================================
  // Interrupt status / mask fields
  localparam int S_TXDONE = 0;
  localparam int S_RXDONE = 1;
  localparam int S_STOP = 2;
  localparam int S_TXREQ = 3;
  localparam int S_GC = 4;
  localparam int S_HGC = 5;
  // ==========================================================
  // Bus codes and counts
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [4:0] WIDE_HDR = 5'h1e;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_END = 4'h8;
  localparam logic [2:0] SYNC_RESET = 3'h7;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ADDR2 = 3'h2,
    ST_RX = 3'h3,
    ST_RACK = 3'h4,
    ST_TX = 3'h5,
    ST_TACK = 3'h6,
    ST_SKIP = 3'h7
  } isc_state_type;
endpackage
`default_nettype wire

// ### isc_slave_ctrl.sv
/*
  Slave-mode control of a two-wire serial interface: APB register file,
  byte engine with address matching, acknowledge, clock stretching,
  general call handling and a masked interrupt.
  Assumes an APB master on pclk and open-drain pins resolved outside.
*/
// Design decision made here: the APB interface to the registers.
// What this block does
// - Byte-sent event raises interrupt status only while transmit enable bit 10 is set.
// - Byte-received event raises interrupt status only while receive enable bit 9 set.
// - Stop condition raises interrupt status only while stop enable bit 8 set.
// - Force-nack bit 7 makes the slave not-acknowledge received bytes.
// - With bit 7 clear, hardware decides acknowledge from address match and state.
// - Stretch bit 6 set with clock low holds clock low until bit cleared.
// - Stretch bit set with clock high holds clock low from next falling edge.
// - Early bit 5 set: transmit request at rising edge of read bit.
// - Early bit clear: transmit request at falling edge after read bit.
// - Writing one to bit 4 clears general-call status; software keeps it zero.
// - Bits 3 and 2 set: byte after general call compared with alternate identifier.
// - Match with alternate identifier marks a hardware general call.
// - Bit 2 set acknowledges general call to zero; clear ignores it.
// - Bit 1 selects ten-bit address matching, clear selects seven-bit.
`default_nettype none
module isc_slave_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  output logic irq
);
  // ==========================================================
  // Pin front end
  isc_pins_if p ();

  isc_pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .p(p)
  );

  // ==========================================================
  // Register file
  logic [15:0] ctrl_reg, ctrl_next;
  logic [9:0] own_reg, own_next;
  logic [7:0] alt_reg, alt_next, txd_reg, txd_next, rxd_reg, rxd_next;
  logic [5:0] ist_reg, ist_next, imsk_reg, imsk_next, ist_set;
  logic [1:0] gst_reg, gst_next;
  logic [31:0] prdata_reg, prdata_next;
  logic hit_reg, hit_next, irq_reg, irq_next, wr;
  logic [3:0] wsel, rsel;

  // Same decode serves the setup-phase read and the access-phase write
  function automatic logic [3:0] reg_sel(input logic [31:0] a);
    if (a == isc_pkg::CTRL_ADDR) reg_sel = 4'h1;
    else if (a == isc_pkg::ALT_ADDR) reg_sel = 4'h2;
    else if (a == isc_pkg::OWN_ADDR) reg_sel = 4'h3;
    else if (a == isc_pkg::TXD_ADDR) reg_sel = 4'h4;
    else if (a == isc_pkg::RXD_ADDR) reg_sel = 4'h5;
    else if (a == isc_pkg::IST_ADDR) reg_sel = 4'h6;
    else if (a == isc_pkg::IMSK_ADDR) reg_sel = 4'h7;
    else if (a == isc_pkg::GST_ADDR) reg_sel = 4'h8;
    else reg_sel = 4'h0;
  endfunction

  assign wr = psel & penable & pwrite & ce;
  assign wsel = reg_sel(paddr);
  assign rsel = reg_sel(paddr);

  // ==========================================================
  // Engine state
  isc_pkg::isc_state_type state_reg, state_next, tgt_reg, tgt_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, txsh_reg, txsh_next, rx_byte;
  logic dir_reg, dir_next, ack_reg, ack_next, gcph_reg, gcph_next;
  logic wm_reg, wm_next, drv_reg, drv_next, hold_reg, hold_next, ok;
  logic tx_done_ev, rx_ev, stop_ev, txreq_ev, gc_ev, hgc_ev;

  always_comb begin
    state_next = state_reg;
    tgt_next = tgt_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    txsh_next = txsh_reg;
    dir_next = dir_reg;
    ack_next = ack_reg;
    gcph_next = gcph_reg;
    wm_next = wm_reg;
    drv_next = drv_reg;
    rxd_next = rxd_reg;
    ok = 1'b0;
    tx_done_ev = 1'b0;
    rx_ev = 1'b0;
    stop_ev = 1'b0;
    txreq_ev = 1'b0;
    gc_ev = 1'b0;
    hgc_ev = 1'b0;
    rx_byte = {sh_reg[6:0], p.sda};
    if (!ctrl_reg[isc_pkg::B_SEN]) begin
      state_next = isc_pkg::ST_IDLE;
      drv_next = 1'b0;
      wm_next = 1'b0;
    end else if (p.stop) begin
      stop_ev = 1'b1;
      state_next = isc_pkg::ST_IDLE;
      drv_next = 1'b0;
      wm_next = 1'b0;
      gcph_next = 1'b0;
    end else if (p.start) begin
      // Repeated start keeps the ten-bit match for the read header
      state_next = isc_pkg::ST_ADDR;
      cnt_next = 4'h0;
      drv_next = 1'b0;
    end else if (p.scl_rise) begin
      case (state_reg)
        isc_pkg::ST_ADDR, isc_pkg::ST_ADDR2, isc_pkg::ST_RX: begin
          sh_next = rx_byte;
          cnt_next = cnt_reg + 4'h1;
          if (cnt_reg == isc_pkg::LAST_BIT) begin
            tgt_next = isc_pkg::ST_RX;
            if (state_reg == isc_pkg::ST_ADDR) begin
              dir_next = rx_byte[0];
              if (rx_byte[7:1] == isc_pkg::GC_ADDR) begin
                ok = ctrl_reg[isc_pkg::B_GCEN] & ~rx_byte[0];
                gc_ev = ok;
                gcph_next = ok;
              end else if (ctrl_reg[isc_pkg::B_WIDE]) begin
                ok = (rx_byte[7:3] == isc_pkg::WIDE_HDR) &&
                  (rx_byte[2:1] == own_reg[9:8]) && (!rx_byte[0] || wm_reg);
                tgt_next = rx_byte[0] ? isc_pkg::ST_TX : isc_pkg::ST_ADDR2;
              end else begin
                ok = (rx_byte[7:1] == own_reg[6:0]);
                tgt_next = rx_byte[0] ? isc_pkg::ST_TX : isc_pkg::ST_RX;
              end
              if (ok && rx_byte[0] && ctrl_reg[isc_pkg::B_EARLY]) begin
                txreq_ev = 1'b1;
              end
            end else if (state_reg == isc_pkg::ST_ADDR2) begin
              ok = (rx_byte == own_reg[7:0]);
              wm_next = ok;
            end else begin
              ok = 1'b1;
              rx_ev = 1'b1;
              rxd_next = rx_byte;
              gcph_next = 1'b0;
              if (gcph_reg && ctrl_reg[isc_pkg::B_HGC] && ctrl_reg[isc_pkg::B_GCEN] &&
                  rx_byte == alt_reg) begin
                hgc_ev = 1'b1;
              end
            end
            ack_next = ok & ~ctrl_reg[isc_pkg::B_NACK];
            if (!(ok & ~ctrl_reg[isc_pkg::B_NACK])) begin
              tgt_next = isc_pkg::ST_SKIP;
            end
          end
        end
        isc_pkg::ST_TX: begin
          cnt_next = cnt_reg + 4'h1;
        end
        isc_pkg::ST_TACK: begin
          ack_next = ~p.sda;
          tx_done_ev = 1'b1;
        end
        default: begin
        end
      endcase
    end else if (p.scl_fall) begin
      case (state_reg)
        isc_pkg::ST_ADDR, isc_pkg::ST_ADDR2, isc_pkg::ST_RX: begin
          if (cnt_reg == isc_pkg::BYTE_END) begin
            cnt_next = 4'h0;
            drv_next = ack_reg;
            state_next = isc_pkg::ST_RACK;
            if (state_reg == isc_pkg::ST_ADDR && dir_reg && ack_reg &&
                !ctrl_reg[isc_pkg::B_EARLY]) begin
              txreq_ev = 1'b1;
            end
          end
        end
        isc_pkg::ST_RACK: begin
          state_next = tgt_reg;
          drv_next = 1'b0;
          if (tgt_reg == isc_pkg::ST_TX) begin
            txsh_next = txd_reg;
            drv_next = ~txd_reg[7];
          end
        end
        isc_pkg::ST_TX: begin
          if (cnt_reg == isc_pkg::BYTE_END) begin
            drv_next = 1'b0;
            state_next = isc_pkg::ST_TACK;
          end else begin
            drv_next = ~txsh_reg[6];
            txsh_next = {txsh_reg[6:0], 1'b0};
          end
        end
        isc_pkg::ST_TACK: begin
          cnt_next = 4'h0;
          if (ack_reg) begin
            state_next = isc_pkg::ST_TX;
            txsh_next = txd_reg;
            drv_next = ~txd_reg[7];
            txreq_ev = 1'b1;
          end else begin
            state_next = isc_pkg::ST_SKIP;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Stretching starts at once on a low clock, else on the next fall
  always_comb begin
    hold_next = ctrl_reg[isc_pkg::B_HOLD] & (hold_reg | ~p.scl | p.scl_fall);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= isc_pkg::ST_IDLE;
      tgt_reg <= isc_pkg::ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= isc_pkg::BYTE_RESET;
      txsh_reg <= isc_pkg::BYTE_RESET;
      dir_reg <= 1'b0;
      ack_reg <= 1'b0;
      gcph_reg <= 1'b0;
      wm_reg <= 1'b0;
      drv_reg <= 1'b0;
      hold_reg <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      tgt_reg <= tgt_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      txsh_reg <= txsh_next;
      dir_reg <= dir_next;
      ack_reg <= ack_next;
      gcph_reg <= gcph_next;
      wm_reg <= wm_next;
      drv_reg <= drv_next;
      hold_reg <= hold_next;
    end
  end

  // ==========================================================
  // Register next values
  always_comb begin
    ctrl_next = ctrl_reg;
    own_next = own_reg;
    alt_next = alt_reg;
    txd_next = txd_reg;
    imsk_next = imsk_reg;
    prdata_next = prdata_reg;
    hit_next = hit_reg;
    ist_set[isc_pkg::S_TXDONE] = tx_done_ev & ctrl_reg[isc_pkg::B_TXI];
    ist_set[isc_pkg::S_RXDONE] = rx_ev & ctrl_reg[isc_pkg::B_RXI];
    ist_set[isc_pkg::S_STOP] = stop_ev & ctrl_reg[isc_pkg::B_STOPI];
    ist_set[isc_pkg::S_TXREQ] = txreq_ev;
    ist_set[isc_pkg::S_GC] = gc_ev;
    ist_set[isc_pkg::S_HGC] = hgc_ev;
    // An event in the clearing cycle wins over the clear
    ist_next = ist_set | ist_reg;
    gst_next = {hgc_ev | gst_reg[1], gc_ev | gst_reg[0]};
    if (wr) begin
      if (wsel == 4'h1) begin
        ctrl_next = pwdata[15:0] & isc_pkg::CTRL_WMASK;
        if (pwdata[isc_pkg::B_GCCLR]) begin
          gst_next = {hgc_ev, gc_ev};
        end
      end else if (wsel == 4'h2) begin
        alt_next = pwdata[7:0];
      end else if (wsel == 4'h3) begin
        own_next = pwdata[9:0];
      end else if (wsel == 4'h4) begin
        txd_next = pwdata[7:0];
      end else if (wsel == 4'h6) begin
        ist_next = ist_set | (ist_reg & ~pwdata[5:0]);
      end else if (wsel == 4'h7) begin
        imsk_next = pwdata[5:0];
      end
    end
    if (psel && !penable) begin
      hit_next = (rsel != 4'h0);
      case (rsel)
        4'h1: prdata_next = {16'h0000, ctrl_reg};
        4'h2: prdata_next = {24'h000000, alt_reg};
        4'h3: prdata_next = {22'h000000, own_reg};
        4'h4: prdata_next = {24'h000000, txd_reg};
        4'h5: prdata_next = {24'h000000, rxd_reg};
        4'h6: prdata_next = {26'h0000000, ist_reg};
        4'h7: prdata_next = {26'h0000000, imsk_reg};
        4'h8: prdata_next = {30'h00000000, gst_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
    irq_next = |(ist_next & imsk_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= isc_pkg::CTRL_RESET;
      own_reg <= isc_pkg::OWN_RESET;
      alt_reg <= isc_pkg::ALT_RESET;
      txd_reg <= isc_pkg::BYTE_RESET;
      rxd_reg <= isc_pkg::BYTE_RESET;
      ist_reg <= isc_pkg::IRQ_RESET;
      imsk_reg <= isc_pkg::IRQ_RESET;
      gst_reg <= 2'h0;
      prdata_reg <= 32'h00000000;
      hit_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else if (ce) begin
      ctrl_reg <= ctrl_next;
      own_reg <= own_next;
      alt_reg <= alt_next;
      txd_reg <= txd_next;
      rxd_reg <= rxd_next;
      ist_reg <= ist_next;
      imsk_reg <= imsk_next;
      gst_reg <= gst_next;
      prdata_reg <= prdata_next;
      hit_reg <= hit_next;
      irq_reg <= irq_next;
    end
  end

  // ==========================================================
  // Outputs; pins are open drain so only enables move
  assign prdata = prdata_reg;
  assign pready = psel & penable & ce;
  assign pslverr = psel & penable & ce & ~hit_reg;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n = ~hold_reg;
  assign sda_oe_n = ~drv_reg;
  assign irq = irq_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  hold_low_a: assert property (ce && ctrl_reg[6] && !p.scl |=> hold_reg)
    else $error("stretch not held with clock low");
  hold_fall_a: assert property (ce && ctrl_reg[6] && p.scl_fall |=> hold_reg)
    else $error("stretch not taken at falling edge");
  hold_release_a: assert property (ce && !ctrl_reg[6] |=> scl_oe_n)
    else $error("clock held after stretch cleared");
  tx_irq_set_a: assert property (ce && tx_done_ev && ctrl_reg[10] |=> ist_reg[0])
    else $error("byte sent status missing");
  tx_irq_gate_a: assert property (ce && !ctrl_reg[10] && !ist_reg[0] && !wr
    |=> !ist_reg[0])
    else $error("byte sent status set while disabled");
  rx_irq_gate_a: assert property (ce && rx_ev |=> ist_reg[1] == $past(ctrl_reg[9])
    || $past(ist_reg[1]))
    else $error("receive status wrong");
  stop_irq_a: assert property (ce && stop_ev && ctrl_reg[8] |=> ist_reg[2])
    else $error("stop status missing");
  force_nack_a: assert property (ce && p.scl_rise && state_reg inside {isc_pkg::ST_ADDR,
    isc_pkg::ST_ADDR2, isc_pkg::ST_RX} &&
    cnt_reg == 4'h7 && ctrl_reg[7] && ctrl_reg[0] && !p.stop && !p.start
    |=> !ack_reg)
    else $error("byte acknowledged under forced nack");
  early_req_a: assert property (txreq_ev && state_reg == isc_pkg::ST_ADDR
    |-> (ctrl_reg[5] ? p.scl_rise : p.scl_fall))
    else $error("transmit request at wrong edge");
  gc_clear_a: assert property (wr && wsel == 4'h1 && pwdata[4] && !gc_ev
    |=> !gst_reg[0])
    else $error("general call status not cleared");
  hw_gc_a: assert property (hgc_ev |-> gcph_reg && ctrl_reg[3] && ctrl_reg[2]
    && rx_byte == alt_reg)
    else $error("hardware general call without cause");
  reserved_zero_a: assert property (ctrl_reg[15:11] == 5'h00)
    else $error("reserved control bits set");

  tx_done_c: cover property (ce && tx_done_ev && ctrl_reg[10]);
  rx_done_c: cover property (ce && rx_ev && ctrl_reg[9]);
  hw_gc_c: cover property (ce && hgc_ev);
  stretch_c: cover property (hold_reg && !p.scl);
endmodule // isc_slave_ctrl
`default_nettype wire

// ### tb_top.sv
/*
  Self-checking bench of the two-wire slave control block.
  Assumes isc_pkg, the design and the master model compile first.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] a; logic [31:0] d; logic [31:0] e; logic x;} isc_reg_type;
  typedef struct {
    logic [15:0] c; logic [7:0] b0; logic [7:0] b1; logic [7:0] g;
    logic [1:0] k; logic [2:0] s1; logic [2:0] s2; logic [1:0] gs;
  } isc_xfer_type;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, ack, ce;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, scl_drv, sda_drv, hung, scl_line, sda_line;
  logic [7:0] got;
  int fail_count = 0;
  int samples_checked = 0;
  isc_reg_type rr [11] = '{'{isc_pkg::CTRL_ADDR, '1, 32'h7ff, 1'h0},
    '{isc_pkg::ALT_ADDR, '1, 32'hff, 1'h0}, '{isc_pkg::OWN_ADDR, '1, 32'h3ff, 1'h0},
    '{isc_pkg::IMSK_ADDR, '1, 32'h3f, 1'h0}, '{isc_pkg::GST_ADDR, '1, 32'h0, 1'h0},
    '{32'hffff0950, '1, 32'h0, 1'h1}, '{isc_pkg::CTRL_ADDR, 32'h0, 32'h0, 1'h0},
    '{isc_pkg::IMSK_ADDR, 32'h7, 32'h7, 1'h0}, '{isc_pkg::OWN_ADDR, 32'h2a5, 32'h2a5, 1'h0},
    '{isc_pkg::ALT_ADDR, 32'h33, 32'h33, 1'h0}, '{isc_pkg::TXD_ADDR, 32'h96, 32'h96, 1'h0}};
  isc_xfer_type xr [11] = '{'{16'h301, 8'h4a, 8'ha5, 8'ha5, 2'h0, 3'h2, 3'h6, 2'h0},
    '{16'h1, 8'h4a, 8'ha5, 8'ha5, 2'h0, 3'h0, 3'h0, 2'h0},
    '{16'h81, 8'h4a, 8'ha5, 8'ha5, 2'h3, 3'h0, 3'h0, 2'h0},
    '{16'h1, 8'h0, 8'h33, 8'h33, 2'h3, 3'h0, 3'h0, 2'h0},
    '{16'h5, 8'h0, 8'h33, 8'h33, 2'h0, 3'h0, 3'h0, 2'h1},
    '{16'hd, 8'h0, 8'h33, 8'h33, 2'h0, 3'h0, 3'h0, 2'h3},
    '{16'hd, 8'h0, 8'h34, 8'h34, 2'h0, 3'h0, 3'h0, 2'h1},
    '{16'h3, 8'hf4, 8'ha5, 8'ha5, 2'h0, 3'h0, 3'h0, 2'h0},
    '{16'h1, 8'hf4, 8'ha5, 8'ha5, 2'h3, 3'h0, 3'h0, 2'h0},
    '{16'h421, 8'h4b, 8'hff, 8'h96, 2'h1, 3'h1, 3'h1, 2'h0},
    '{16'h1, 8'h4b, 8'hff, 8'h96, 2'h1, 3'h0, 3'h0, 2'h0}};
  assign scl_line = scl_drv & (scl_oe_n | scl_out);
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  isc_slave_ctrl dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_line), .sda_in(sda_line),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .irq(irq));
  isc_master_model bus_u (.pclk(pclk), .scl_line(scl_line), .sda_line(sda_line),
    .scl_drv(scl_drv), .sda_drv(sda_drv), .hung(hung));
  // ==========================================================
  // Helpers
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // No wait states assumed: pready is polled, bounded
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      fail_count++;
      test_done();
    end
  endtask
  initial begin
    repeat (90000) @(posedge pclk);
    fail_count++;
    test_done();
  end
  // ==========================================================
  // Sequence
  initial begin
    presetn = 1'h0;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, isc_pkg::CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk({irq, scl_oe_n, sda_oe_n}, 3'h3);
    foreach (rr[i]) begin
      apb(1'h1, rr[i].a, rr[i].d);
      chk(err, rr[i].x);
      apb(1'h0, rr[i].a, 32'h0);
      chk(rd, rr[i].e);
    end
    foreach (xr[i]) begin
      apb(1'h1, isc_pkg::CTRL_ADDR, {16'h0, xr[i].c});
      bus_u.start_cond();
      bus_u.xfer(xr[i].b0, got, ack);
      chk(ack, xr[i].k[1]);
      bus_u.xfer(xr[i].b1, got, ack);
      chk({got, ack}, {xr[i].g, xr[i].k[0]});
      apb(1'h0, isc_pkg::IST_ADDR, 32'h0);
      chk(rd & 32'h7, xr[i].s1);
      chk(rd[3], xr[i].b0[0] & ~xr[i].k[1]);
      bus_u.stop_cond();
      apb(1'h0, isc_pkg::IST_ADDR, 32'h0);
      chk({irq, rd[2:0]}, {xr[i].s2 != 3'h0, xr[i].s2});
      apb(1'h0, isc_pkg::GST_ADDR, 32'h0);
      chk(rd, xr[i].gs);
      apb(1'h1, isc_pkg::CTRL_ADDR, {16'h0, xr[i].c | 16'h10});
      apb(1'h0, isc_pkg::GST_ADDR, 32'h0);
      chk(rd, 32'h0);
      apb(1'h1, isc_pkg::CTRL_ADDR, {16'h0, xr[i].c});
      apb(1'h1, isc_pkg::IST_ADDR, 32'h3f);
    end
    // Last byte taken in by the receive path
    apb(1'h0, isc_pkg::RXD_ADDR, 32'h0);
    chk(rd, {24'h0, xr[6].b1});
    // Stretch armed with clock high, then held across a whole bit
    apb(1'h1, isc_pkg::CTRL_ADDR, 32'h41);
    repeat (4) @(posedge pclk);
    chk(scl_oe_n, 1'h1);
    bus_u.start_cond();
    repeat (4) @(posedge pclk);
    chk(scl_oe_n, 1'h0);
    fork
      bus_u.xfer(8'h4a, got, ack);
      begin
        repeat (60) @(posedge pclk);
        chk(scl_line, 1'h0);
        apb(1'h1, isc_pkg::CTRL_ADDR, 32'h1);
      end
    join
    chk({hung, ack}, 2'h0);
    bus_u.stop_cond();
    // Frozen clock enable stalls the access phase until it returns
    ce <= 1'h0;
    fork
      apb(1'h1, isc_pkg::ALT_ADDR, 32'h5a);
      begin
        repeat (6) @(posedge pclk);
        chk(pready, 1'h0);
        ce <= 1'h1;
      end
    join
    apb(1'h0, isc_pkg::ALT_ADDR, 32'h0);
    chk(rd, 32'h5a);
    // Reset in mid-run brings the registers back to their reset values
    presetn <= 1'h0;
    @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, isc_pkg::ALT_ADDR, 32'h0);
    chk(rd, {24'h0, isc_pkg::ALT_RESET});
    apb(1'h0, isc_pkg::CTRL_ADDR, 32'h0);
    chk(rd, {16'h0, isc_pkg::CTRL_RESET});
    chk({irq, scl_oe_n, sda_oe_n}, 3'h3);
    test_done();
  end
endmodule // tb_top
`default_nettype wire
